/* design/svt_pkg.sv */
// System-control instruction unit: shared constants for the core and its helpers.
// Assumes a 16-bit flag word and a 32-bit classic Wishbone register bus.
package svt_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_SRC = 8'h04;
  localparam logic [7:0] ADR_FLAG = 8'h08;
  localparam logic [7:0] ADR_RESULT = 8'h0c;
  localparam logic [7:0] ADR_VEC = 8'h10;
  localparam logic [7:0] ADR_SAVE = 8'h14;
  localparam logic [7:0] ADR_FSAVE = 8'h18;
  localparam logic [7:0] ADR_STAT = 8'h1c;
  localparam logic [7:0] ADR_MASK = 8'h20;
  // Instruction word fields
  localparam int OPC_LSB = 0;
  localparam int SEL_LSB = 4;
  localparam int IMM_LSB = 8;
  // Opcodes
  localparam logic [3:0] OP_BRK = 4'h0;
  localparam logic [3:0] OP_DEBUGGER_BREAK_INSTR = 4'h1;
  localparam logic [3:0] OP_FLAG_CLEAR_INSTR = 4'h2;
  localparam logic [3:0] OP_FLAG_SET_INSTR = 4'h3;
  localparam logic [3:0] OP_FAST_RETURN_FROM_EXCEPTION = 4'h4;
  localparam logic [3:0] OP_INT = 4'h5;
  localparam logic [3:0] OP_INTO = 4'h6;
  localparam logic [3:0] OP_LDC = 4'h7;
  localparam logic [3:0] OP_SET_PRIORITY_LEVEL_INSTR = 4'h8;
  localparam logic [3:0] OP_RETURN_FROM_EXCEPTION = 4'h9;
  localparam logic [3:0] OP_STC = 4'ha;
  localparam logic [3:0] OP_UND = 4'hb;
  // Flag register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam int IPL_LSB = 12;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  // Dedicated register indices
  localparam logic [2:0] CR_FLG = 3'h5;
  localparam logic [2:0] CR_PC = 3'h6;
  // Fixed trap vectors
  localparam logic [7:0] VEC_UND = 8'h40;
  localparam logic [7:0] VEC_INTO = 8'h41;
  localparam logic [7:0] VEC_BRK = 8'h42;
  localparam logic [7:0] VEC_DEBUGGER_BREAK_INSTR = 8'h43;
  // Status and mask bits
  localparam int ST_TRAP = 0;
  localparam int ST_DECERR = 1;
  localparam int ST_RET = 2;
endpackage : svt_pkg

/* design/svt_creg_file.sv */
// Dedicated control register storage, eight 16-bit words.
// Assumes the caller never writes the flag or program counter slots.
`timescale 1ns/100ps
module svt_creg_file (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [2:0] i_widx,
  input wire logic [15:0] i_wdat,
  input wire logic [2:0] i_ridx,
  output logic [15:0] o_rdat
);
  import svt_pkg::*;

  typedef struct packed {
    logic [7:0][15:0] regs;
  } svt_creg_t;

  svt_creg_t q;
  svt_creg_t d;

  // Next state: single write port
  always_comb begin
    d = q;
    if (i_we) begin
      d.regs[i_widx] = i_wdat;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Read is combinational so the core can latch it in the same cycle
  assign o_rdat = q.regs[i_ridx];
endmodule : svt_creg_file

/* design/svt_trap_vec.sv */
// Trap decision and vector selection for the trap opcodes.
// Assumes opcode and immediate come straight from the instruction word.
`timescale 1ns/100ps
module svt_trap_vec (
  input wire logic [3:0] i_op,
  input wire logic [5:0] i_imm,
  input wire logic i_ovf,
  output logic o_take,
  output logic [7:0] o_vec
);
  import svt_pkg::*;

  // Pure decode, no state
  always_comb begin
    o_take = 1'b0;
    o_vec = 8'h00;
    case (i_op)
      OP_BRK: begin
        o_take = 1'b1; // RULE15
        o_vec = VEC_BRK;
      end
      OP_DEBUGGER_BREAK_INSTR: begin
        o_take = 1'b1;
        o_vec = VEC_DEBUGGER_BREAK_INSTR;
      end
      OP_INT: begin
        o_take = 1'b1;
        o_vec = {2'h0, i_imm}; // RULE5
      end
      OP_INTO: begin
        o_take = i_ovf; // RULE6
        o_vec = VEC_INTO;
      end
      OP_UND: begin
        o_take = 1'b1; // RULE13
        o_vec = VEC_UND;
      end
      default: begin
        o_take = 1'b0;
      end
    endcase
  end
endmodule : svt_trap_vec

/* design/svt_core.sv */
// System-control instruction unit: traps, returns, flag and control register ops.
// Assumes a classic Wishbone master, and interrupt-accept strobes from core logic.
// Function
// [RULE1] Debugger break is reserved for the debugger
// [RULE2] Flag clear zeroes only the selected flag
// [RULE3] Flag set ones only the selected flag
// [RULE4] Fast return restores state from fast entry
// [RULE5] Software trap vectors by its immediate number
// [RULE6] Overflow trap fires only when overflow set
// [RULE7] Control load copies source to named register
// [RULE8] Program counter never accepted as control register
// [RULE9] Priority load copies immediate into level field
// [RULE10] Software keeps priority immediate between 0, 7
// [RULE11] Exception return restores pre-interrupt flags
// [RULE12] Control store copies named register to result
// [RULE13] Undefined opcode trap raises its exception
// [RULE14] Taken traps clear stack, interrupt, debug flags
// [RULE15] Break trap is unconditional with its vector
`timescale 1ns/100ps
module svt_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_irq_accept,
  input wire logic i_fast_accept,
  output logic o_trap_req,
  output logic [7:0] o_trap_vec,
  output logic o_irq
);
  import svt_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [15:0] instr;
    logic [15:0] src;
    logic [15:0] flag;
    logic [15:0] result;
    logic [7:0] vec;
    logic trap;
    logic [15:0] save;
    logic [15:0] fsave;
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;
  } svt_core_t;

  svt_core_t q;
  svt_core_t d;

  logic req;
  logic exec;
  logic [3:0] op;
  logic [2:0] sel;
  logic [5:0] imm;
  logic take;
  logic [7:0] tvec;
  logic creg_we;
  logic [15:0] creg_rd;
  logic [2:0] ev;
  logic [15:0] w1c;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] wmerge(input logic [15:0] old_v, input logic [15:0] new_v,
                                         input logic [1:0] lanes);
    logic [15:0] r;
    r = old_v;
    if (lanes[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (lanes[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : wmerge

  // Bus request decode; ack follows one cycle after the strobe
  assign req = i_wb_cyc && i_wb_stb && !q.ack;
  // The instruction word only issues when both low lanes are written
  assign exec = req && i_wb_we && (i_wb_adr == ADR_INSTR) && (&i_wb_sel[1:0]);
  assign op = i_wb_dat[OPC_LSB +: 4];
  assign sel = i_wb_dat[SEL_LSB +: 3];
  assign imm = i_wb_dat[IMM_LSB +: 6];
  // Control load writes the storage file except the flag and PC slots
  assign creg_we = exec && (op == OP_LDC) && (sel != CR_PC) && (sel != CR_FLG); // RULE7 RULE8
  assign w1c = (req && i_wb_we && (i_wb_adr == ADR_STAT)) ?
               wmerge(16'h0000, i_wb_dat[15:0], i_wb_sel[1:0]) : 16'h0000;

  svt_trap_vec u_trap_vec (
    .i_op(op),
    .i_imm(imm),
    .i_ovf(q.flag[FLG_O]),
    .o_take(take),
    .o_vec(tvec)
  );

  svt_creg_file u_creg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(creg_we),
    .i_widx(sel),
    .i_wdat(q.src),
    .i_ridx(sel),
    .o_rdat(creg_rd)
  );

  // Next-state logic for bus, instruction execution and interrupt status
  always_comb begin
    d = q;
    ev = 3'h0;
    d.trap = 1'b0;
    d.ack = req;
    // Accepted interrupts snapshot the flags for the matching return
    if (i_irq_accept) begin
      d.save = q.flag;
    end
    if (i_fast_accept) begin
      d.fsave = q.flag; // RULE4
    end
    // Read data is captured with ack and held until the next read
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        ADR_INSTR: d.rdat = {16'h0000, q.instr};
        ADR_SRC: d.rdat = {16'h0000, q.src};
        ADR_FLAG: d.rdat = {16'h0000, q.flag};
        ADR_RESULT: d.rdat = {16'h0000, q.result};
        ADR_VEC: d.rdat = {24'h000000, q.vec};
        ADR_SAVE: d.rdat = {16'h0000, q.save};
        ADR_FSAVE: d.rdat = {16'h0000, q.fsave};
        ADR_STAT: d.rdat = {29'h00000000, q.stat};
        ADR_MASK: d.rdat = {29'h00000000, q.mask};
        default: d.rdat = 32'h00000000;
      endcase
    end
    // Plain register writes; unmapped writes are acked and dropped
    if (req && i_wb_we) begin
      case (i_wb_adr)
        ADR_SRC: d.src = wmerge(q.src, i_wb_dat[15:0], i_wb_sel[1:0]);
        ADR_MASK: d.mask = 3'(wmerge({13'h0000, q.mask}, i_wb_dat[15:0], i_wb_sel[1:0]));
        default: d.src = d.src;
      endcase
    end
    // Instruction issue
    if (exec) begin
      d.instr = i_wb_dat[15:0];
      case (op)
        OP_FLAG_CLEAR_INSTR: d.flag[sel] = 1'b0; // RULE2
        OP_FLAG_SET_INSTR: d.flag[sel] = 1'b1; // RULE3
        OP_LDC: begin
          if (sel == CR_PC) begin
            ev[ST_DECERR] = 1'b1; // RULE8
          end else if (sel == CR_FLG) begin
            d.flag = q.src; // RULE7
          end
        end
        OP_STC: begin
          if (sel == CR_PC) begin
            ev[ST_DECERR] = 1'b1; // RULE8
          end else begin
            d.result = (sel == CR_FLG) ? q.flag : creg_rd; // RULE12
          end
        end
        // Range 0..7 is the software's duty; all three bits are copied as given
        OP_SET_PRIORITY_LEVEL_INSTR: d.flag[IPL_LSB +: 3] = imm[2:0]; // RULE9 RULE10
        OP_RETURN_FROM_EXCEPTION: begin
          d.flag = q.save; // RULE11
          ev[ST_RET] = 1'b1;
        end
        OP_FAST_RETURN_FROM_EXCEPTION: begin
          d.flag = q.fsave; // RULE4
          ev[ST_RET] = 1'b1;
        end
        // Debugger break is still decoded so a debugger can use it
        OP_BRK, OP_DEBUGGER_BREAK_INSTR, OP_INT, OP_INTO, OP_UND: d.trap = 1'b0; // RULE1
        default: ev[ST_DECERR] = 1'b1;
      endcase
      // Trap entry saves the flags for the return and masks the handler
      if (take) begin
        d.save = q.flag;
        d.flag[FLG_U] = 1'b0; // RULE14
        d.flag[FLG_I] = 1'b0; // RULE14
        d.flag[FLG_D] = 1'b0; // RULE14
        d.vec = tvec; // RULE5
        d.trap = 1'b1; // RULE13 RULE15
        ev[ST_TRAP] = 1'b1;
      end
    end
    // A new event wins over a same-cycle write-one-to-clear
    d.stat = (q.stat & ~w1c[2:0]) | ev;
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.flag <= FLAG_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign o_wb_ack = q.ack;
  assign o_wb_dat = q.rdat;
  assign o_trap_req = q.trap;
  assign o_trap_vec = q.vec;
  assign o_irq = q.irq;

  // Checks on the execution paths
  property p_flag_clear_instr;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_FLAG_CLEAR_INSTR) |=> (q.flag[$past(sel)] == 1'b0);
  endproperty
  a_flag_clear_instr: assert property (p_flag_clear_instr) else $error("flag clear left bit set"); // RULE2

  property p_flag_set_instr;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_FLAG_SET_INSTR) |=> (q.flag == ($past(q.flag) | (16'h0001 << $past(sel))));
  endproperty
  a_flag_set_instr: assert property (p_flag_set_instr) else $error("flag set changed wrong bits"); // RULE3

  property p_fast_return_from_exception;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_FAST_RETURN_FROM_EXCEPTION) |=> (q.flag == $past(q.fsave)) && q.stat[ST_RET];
  endproperty
  a_fast_return_from_exception: assert property (p_fast_return_from_exception) else $error("fast return flags wrong"); // RULE4

  property p_int;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_INT) |=> o_trap_req && (o_trap_vec == {2'h0, $past(imm)}) ##1 !o_trap_req;
  endproperty
  a_int: assert property (p_int) else $error("software trap vector wrong"); // RULE5

  property p_into;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_INTO) |=> (o_trap_req == $past(q.flag[FLG_O]));
  endproperty
  a_into: assert property (p_into) else $error("overflow trap condition wrong"); // RULE6

  property p_ldc_pc;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && (op == OP_LDC || op == OP_STC) && sel == CR_PC) |=>
      q.stat[ST_DECERR] && $stable(q.flag) ##1 (!q.mask[ST_DECERR] || o_irq);
  endproperty
  a_ldc_pc: assert property (p_ldc_pc) else $error("program counter accepted"); // RULE8

  property p_set_priority_level_instr;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_SET_PRIORITY_LEVEL_INSTR) |=> (q.flag[IPL_LSB +: 3] == $past(imm[2:0]));
  endproperty
  a_set_priority_level_instr: assert property (p_set_priority_level_instr) else $error("priority level not loaded"); // RULE9

  property p_return_from_exception;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_RETURN_FROM_EXCEPTION) |=> (q.flag == $past(q.save));
  endproperty
  a_return_from_exception: assert property (p_return_from_exception) else $error("return flags not restored"); // RULE11

  property p_und;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_UND) |=> o_trap_req && (o_trap_vec == VEC_UND);
  endproperty
  a_und: assert property (p_und) else $error("undefined trap not raised"); // RULE13

  property p_trap_flags;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_trap_req |-> !q.flag[FLG_U] && !q.flag[FLG_I] && !q.flag[FLG_D];
  endproperty
  a_trap_flags: assert property (p_trap_flags) else $error("trap left flags set"); // RULE14

  property p_brk;
    @(posedge i_clk) disable iff (!i_rst_n)
    (exec && op == OP_BRK) |=> o_trap_req && (o_trap_vec == VEC_BRK) && q.stat[ST_TRAP];
  endproperty
  a_brk: assert property (p_brk) else $error("break trap not raised"); // RULE15

  property p_ack;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");

  // Main scenarios
  c_trap: cover property (@(posedge i_clk) disable iff (!i_rst_n) exec && take);
  c_ret: cover property (@(posedge i_clk) disable iff (!i_rst_n) exec && op == OP_RETURN_FROM_EXCEPTION);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq));
endmodule : svt_core

/* test/svt_core_tb.sv */
// Self-checking bench for the system-control instruction unit.
// Assumes one 20 MHz clock; drives the Wishbone port and accept strobes directly.
`timescale 1ns/100ps
module svt_core_tb;
  import svt_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0;
  logic i_irq_accept = 1'b0;
  logic i_fast_accept = 1'b0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic o_trap_req;
  logic [7:0] o_trap_vec;
  logic o_irq;
  int num_errors = 0;
  int checked = 0;
  logic [15:0] fl;
  logic [15:0] sv;
  logic [15:0] fs;
  // Trap table: opcode, immediate, expected vector
  logic [3:0] t_op [5] = '{OP_BRK, OP_DEBUGGER_BREAK_INSTR, OP_UND, OP_INT, OP_INT};
  logic [5:0] t_imm [5] = '{6'h00, 6'h00, 6'h00, 6'h3f, 6'h05};
  logic [7:0] t_vec [5] = '{VEC_BRK, VEC_DEBUGGER_BREAK_INSTR, VEC_UND, 8'h3f, 8'h05};

  // Clock generator, 50 ns period
  always #25 i_clk = ~i_clk;

  svt_core DUT (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_irq_accept(i_irq_accept),
    .i_fast_accept(i_fast_accept),
    .o_trap_req(o_trap_req),
    .o_trap_vec(o_trap_vec),
    .o_irq(o_irq)
  );

  // Verdict and end of run
  task automatic results();
    $display("checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk

  // Classic single cycle; trap pulse is sampled on the same edge as ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic t);
    int n;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    t = o_trap_req;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    if (o_wb_ack !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask : wb

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic t;
    wb(1'b0, a, 32'h0, q, t);
    chk(n, q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic t;
    wb(1'b1, a, d, q, t);
  endtask : wr

  // Issue one instruction, check trap pulse, vector and resulting flags
  task automatic op(input logic [3:0] o, input logic [2:0] s, input logic [5:0] m,
      input logic et, input logic [7:0] ev);
    logic [31:0] q;
    logic t;
    wb(1'b1, ADR_INSTR, {18'h0, m, 1'b0, s, o}, q, t);
    chk("trap", {31'h0, t}, {31'h0, et});
    if (et) begin
      chk("vec", {24'h0, o_trap_vec}, {24'h0, ev});
      sv = fl;
      fl[FLG_U] = 1'b0;
      fl[FLG_I] = 1'b0;
      fl[FLG_D] = 1'b0;
    end
    rd("flag", ADR_FLAG, {16'h0, fl});
  endtask : op

  task automatic pulse(input logic fast);
    @(posedge i_clk);
    i_fast_accept <= fast;
    i_irq_accept <= ~fast;
    @(posedge i_clk);
    i_fast_accept <= 1'b0;
    i_irq_accept <= 1'b0;
  endtask : pulse

  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    fl = 16'h0;
    rd("flag", ADR_FLAG, 32'h0);
    rd("stat", ADR_STAT, 32'h0);
    rd("unmapped", 8'h24, 32'h0);
    wr(ADR_MASK, 32'h7);
    rd("mask", ADR_MASK, 32'h7);
    for (int i = 0; i < 8; i++) begin
      fl[i] = 1'b1;
      op(OP_FLAG_SET_INSTR, 3'(i), 6'h0, 1'b0, 8'h0);
    end
    fl[FLG_Z] = 1'b0;
    op(OP_FLAG_CLEAR_INSTR, 3'(FLG_Z), 6'h0, 1'b0, 8'h0);
    chk("irq", {31'h0, o_irq}, 32'h0);
    // Overflow set: trap taken, status event raises the interrupt
    op(OP_INTO, 3'h0, 6'h0, 1'b1, VEC_INTO);
    rd("save", ADR_SAVE, {16'h0, sv});
    rd("stat", ADR_STAT, 32'h1);
    chk("irq", {31'h0, o_irq}, 32'h1);
    wr(ADR_STAT, 32'h1);
    rd("stat", ADR_STAT, 32'h0);
    chk("irq", {31'h0, o_irq}, 32'h0);
    fl = sv;
    op(OP_RETURN_FROM_EXCEPTION, 3'h0, 6'h0, 1'b0, 8'h0);
    fl[FLG_O] = 1'b0;
    op(OP_FLAG_CLEAR_INSTR, 3'(FLG_O), 6'h0, 1'b0, 8'h0);
    op(OP_INTO, 3'h0, 6'h0, 1'b0, 8'h0);
    for (int i = 0; i < 5; i++) begin
      op(t_op[i], 3'h0, t_imm[i], 1'b1, t_vec[i]);
      rd("vecreg", ADR_VEC, {24'h0, t_vec[i]});
      fl = sv;
      op(OP_RETURN_FROM_EXCEPTION, 3'h0, 6'h0, 1'b0, 8'h0);
    end
    fl[14:12] = 3'h5;
    op(OP_SET_PRIORITY_LEVEL_INSTR, 3'h0, 6'h05, 1'b0, 8'h0);
    fl[14:12] = 3'h6;
    op(OP_SET_PRIORITY_LEVEL_INSTR, 3'h0, 6'h06, 1'b0, 8'h0);
    // Every storage slot except the flag and PC slots loaded, then read back
    for (int k = 0; k < 8; k++) begin
      if (k != 5 && k != 6) begin
        wr(ADR_SRC, 32'(16'ha000 + k));
        op(OP_LDC, 3'(k), 6'h0, 1'b0, 8'h0);
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (k != 5 && k != 6) begin
        op(OP_STC, 3'(k), 6'h0, 1'b0, 8'h0);
        rd("result", ADR_RESULT, 32'(16'ha000 + k));
      end
    end
    wr(ADR_SRC, 32'h30a5);
    fl = 16'h30a5;
    op(OP_LDC, CR_FLG, 6'h0, 1'b0, 8'h0);
    op(OP_STC, CR_FLG, 6'h0, 1'b0, 8'h0);
    rd("result", ADR_RESULT, {16'h0, fl});
    // Program counter slot is refused and flagged as a decode error
    wr(ADR_STAT, 32'h7);
    op(OP_LDC, CR_PC, 6'h0, 1'b0, 8'h0);
    rd("stat", ADR_STAT, 32'h2);
    chk("irq", {31'h0, o_irq}, 32'h1);
    op(OP_STC, CR_PC, 6'h0, 1'b0, 8'h0);
    rd("result", ADR_RESULT, {16'h0, fl});
    // Fast entry saves flags; fast return brings them back
    pulse(1'b1);
    fs = fl;
    rd("fsave", ADR_FSAVE, {16'h0, fs});
    fl[FLG_C] = 1'b0;
    op(OP_FLAG_CLEAR_INSTR, 3'(FLG_C), 6'h0, 1'b0, 8'h0);
    fl = fs;
    op(OP_FAST_RETURN_FROM_EXCEPTION, 3'h0, 6'h0, 1'b0, 8'h0);
    fl[FLG_B] = 1'b1;
    op(OP_FLAG_SET_INSTR, 3'(FLG_B), 6'h0, 1'b0, 8'h0);
    pulse(1'b0);
    rd("save", ADR_SAVE, {16'h0, fl});
    wr(ADR_STAT, 32'h7);
    rd("stat", ADR_STAT, 32'h0);
    chk("irq", {31'h0, o_irq}, 32'h0);
    results();
  end
endmodule : svt_core_tb
